// File: rtl/seq_consts.svh
// constants for the codec startup and power sequencer
// assumes a 200 MHz core_clk; times kept in microseconds
`ifndef SEQ_CONSTS_SVH
`define SEQ_CONSTS_SVH
`define CLK_MHZ          200
`define POR_TIME_US      14000
`define LOCK_TIME_US     2960
`define POR_CYCLES       (`POR_TIME_US * `CLK_MHZ)
`define LOCK_CYCLES      (`LOCK_TIME_US * `CLK_MHZ)
// register byte offsets
`define OFF_CLK_CTRL     12'h000
`define OFF_PLL_CTRL     12'h004
`define OFF_PWR_CTRL     12'h008
`define OFF_FILT_CTRL    12'h00c
`define OFF_PORT_CTRL    12'h010
`define OFF_STATUS       12'h014
`define OFF_IRQ_STAT     12'h018
`define OFF_IRQ_CLR      12'h01c
`define OFF_IRQ_EN       12'h020
`define OFF_RATE_CTRL    12'h024
// clock control fields
`define CLK_CORE_EN_BIT  0
`define CLK_SRC_BIT      3
// power control fields
`define PWR_ADC_BIT      0
`define PWR_DAC_BIT      1
`define PWR_PLL_BIT      2
`define PWR_DSP_BIT      3
// filter control: 1 selects 128x
`define FILT_ADC_BIT     0
`define FILT_DAC_BIT     1
`define FILT_RST         2'h3
// pll control: bit 0 start, reset value of settings
`define PLL_START_BIT    0
`define PLL_RST          32'h0000_1000
// status fields
`define ST_LOCK_BIT      0
`define ST_POR_BIT       1
`define ST_READY_BIT     2
// interrupt events
`define IRQ_LOCK_BIT     0
`define IRQ_UNLOCK_BIT   1
`define IRQ_BAD_BIT      2
`define IRQ_W            3
`endif

// File: rtl/seq_pkg.sv
// types for the codec startup and power sequencer
// assumes seq_consts.svh holds every number
package seq_pkg;
   typedef enum logic [1:0] {
      FMT_I2S, FMT_LEFT, FMT_RIGHT, FMT_TDM
   } port_fmt_t;
   typedef enum logic [1:0] {
      PLL_OFF, PLL_ACQ, PLL_LOCKED
   } pll_state_t;
endpackage : seq_pkg

// File: rtl/seq_if.sv
// timer request and done between sequencer and its counters
// assumes one clock domain
`timescale 1ns/10ps
interface seq_if;
   logic start;
   logic busy;
   logic done;
   modport owner (output start, input busy, input done);
   modport timer (input start, output busy, output done);
endinterface : seq_if

// File: rtl/seq_timer.sv
// one-shot cycle counter: done pulses COUNT cycles after start
// assumes start is a one-cycle pulse; restart reloads
`timescale 1ns/10ps
module seq_timer #(
   parameter int COUNT = 16
) (
   input  wire logic core_clk,   // core clock
   input  wire logic rst_n,      // async reset, low
   input  wire logic abort,      // stop counting
   seq_if.timer      tif         // request and done
);
   localparam int W = $clog2(COUNT + 1);
   logic [W-1:0] cnt_r;
   logic         busy_r;
   logic         done_r;
   if (COUNT < 1) begin : g_bad_count
      $error("seq_timer: COUNT must be at least 1");
   end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r  <= '0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         done_r <= 1'b0;
         if (abort) begin
            busy_r <= 1'b0;
         end else if (tif.start) begin
            cnt_r  <= W'(COUNT - 1);
            busy_r <= 1'b1;
         end else if (busy_r) begin
            if (cnt_r == '0) begin
               busy_r <= 1'b0;
               done_r <= 1'b1;
            end else begin
               cnt_r <= cnt_r - 1'b1;
            end
         end
      end
   end
   assign tif.busy = busy_r;
   assign tif.done = done_r;
endmodule : seq_timer

// File: rtl/seq_sync.sv
// two-flop synchroniser for pin levels
// assumes inputs are asynchronous levels
`timescale 1ns/10ps
module seq_sync #(
   parameter int W = 1
) (
   input  wire logic         core_clk, // core clock
   input  wire logic         rst_n,    // async reset, low
   input  wire logic [W-1:0] d,        // async level
   output logic      [W-1:0] q         // synchronised level
);
   logic [W-1:0] meta_r;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule : seq_sync

// File: rtl/codec_startup_power_sequencer.sv
// startup, reset and power sequencing for the codec core
// assumes an apb master on core_clk and a supply-good level pin
`timescale 1ns/10ps
`include "seq_consts.svh"
// Notes on behaviour
// - power-on reset restores every register default except interrupt status
// - power-on reset holds about 14 ms
// - lock asserts after lock acquisition time
// - dsp may start right after lock
// - adc, dac, pll, dsp powered independently
// - adc/dac filters pick 64x or 128x
// - serial port format: i2s, left, right, tdm
// - converter rate scales base rate 8-96 kHz
// - pll takes 8 to 27 MHz reference
// - core clock off until enable bit set
// - core clock enable resets to zero
module codec_startup_power_sequencer #(
   parameter int POR_CYCLES  = `POR_CYCLES,
   parameter int LOCK_CYCLES = `LOCK_CYCLES
) (
   input  wire logic        core_clk,      // 200 MHz clock
   input  wire logic        rst_n,         // async reset, low
   input  wire logic        core_supply_point, // supply good pin
   input  wire logic        psel,          // apb select
   input  wire logic        penable,       // apb enable
   input  wire logic        pwrite,        // apb direction
   input  wire logic [11:0] paddr,         // apb byte address
   input  wire logic [31:0] pwdata,        // apb write data
   output logic      [31:0] prdata,        // apb read data
   output logic             pready,        // apb ready
   output logic             pslverr,       // apb error
   output logic             core_clk_gate, // core clock running
   output logic             pll_lock,      // pll locked
   output logic             por_active,    // power-on reset held
   output logic       [3:0] blk_power,     // dsp,pll,dac,adc on
   output logic       [1:0] filt_128x,     // dac,adc at 128x
   output logic       [1:0] port_fmt,      // serial framing
   output logic       [2:0] conv_rate,     // rate scaling code
   output logic             irq            // level interrupt
);
   // =========================================================
   // parameter checks
   // =========================================================
   // a zero count gives a zero-width timer that never ends
   if (POR_CYCLES < 1) begin : g_bad_por
      $error("POR_CYCLES must be at least 1");
   end
   if (LOCK_CYCLES < 1) begin : g_bad_lock
      $error("LOCK_CYCLES must be at least 1");
   end
   // =========================================================
   // supply monitor and power-on reset
   // =========================================================
   logic supply_ok;
   logic supply_ok_d_r;
   logic por_r;
   logic por_start;
   seq_if por_if ();
   seq_if lock_if ();
   seq_sync #(.W(1)) u_sync (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .d        (core_supply_point),
      .q        (supply_ok)
   );
   assign por_start = supply_ok & ~supply_ok_d_r;
   assign por_if.start = por_start;
   seq_timer #(.COUNT(POR_CYCLES)) u_por (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .abort    (~supply_ok),
      .tif      (por_if)
   );
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         supply_ok_d_r <= 1'b0;
         por_r         <= 1'b1;
      end else begin
         supply_ok_d_r <= supply_ok;
         // reset held while supply low or timing
         if (!supply_ok || por_start) begin
            por_r <= 1'b1;
         end else if (por_if.done) begin
            por_r <= 1'b0;
         end
      end
   end
   // =========================================================
   // apb decode
   // =========================================================
   logic        wr_en;
   logic        rd_en;
   logic        addr_ok;
   logic        early_ok;
   logic        acc_ok;
   logic        ready_ok;
   logic [31:0] rd_val;
   logic [31:0] clk_ctrl_r;
   logic [31:0] pll_ctrl_r;
   logic [3:0]  pwr_r;
   logic [1:0]  filt_r;
   logic [1:0]  fmt_r;
   logic [2:0]  rate_r;
   logic [`IRQ_W-1:0] irq_stat_r;
   logic [`IRQ_W-1:0] irq_en_r;
   logic [`IRQ_W-1:0] irq_set;
   seq_pkg::pll_state_t pll_st_r;
   assign addr_ok = (paddr[1:0] == 2'h0) && (paddr <= `OFF_RATE_CTRL);
   // only clock, pll, power and status during lock
   // power stays reachable: pll must be powered down first
   assign early_ok = (paddr == `OFF_CLK_CTRL) ||
                     (paddr == `OFF_PLL_CTRL) ||
                     (paddr == `OFF_PWR_CTRL) ||
                     (paddr == `OFF_STATUS);
   assign ready_ok = clk_ctrl_r[`CLK_CORE_EN_BIT] &&
                     (!clk_ctrl_r[`CLK_SRC_BIT] ||
                      pll_st_r == seq_pkg::PLL_LOCKED);
   assign acc_ok = addr_ok && !por_r && (early_ok || ready_ok);
   assign wr_en  = psel && penable && pwrite && acc_ok && !pready;
   assign rd_en  = psel && penable && !pwrite && !pready;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end else begin
         // one wait state: answer on the second access cycle
         pready  <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !acc_ok;
         prdata  <= (rd_en && acc_ok) ? rd_val : 32'h0;
      end
   end
   always_comb begin
      rd_val = 32'h0;
      unique case (paddr)
         `OFF_CLK_CTRL:  rd_val = clk_ctrl_r;
         `OFF_PLL_CTRL:  rd_val = pll_ctrl_r;
         `OFF_PWR_CTRL:  rd_val = {28'h0, pwr_r};
         `OFF_FILT_CTRL: rd_val = {30'h0, filt_r};
         `OFF_PORT_CTRL: rd_val = {30'h0, fmt_r};
         `OFF_STATUS:    rd_val = {29'h0, ready_ok, por_r,
                                   pll_st_r == seq_pkg::PLL_LOCKED};
         `OFF_IRQ_STAT:  rd_val = {29'h0, irq_stat_r};
         // clear register is write-only
         `OFF_IRQ_CLR:   rd_val = 32'h0;
         `OFF_IRQ_EN:    rd_val = {29'h0, irq_en_r};
         `OFF_RATE_CTRL: rd_val = {29'h0, rate_r};
         default:        rd_val = 32'h0;
      endcase
   end
   // =========================================================
   // control registers, all returned to reset values by power-on reset
   // =========================================================
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         clk_ctrl_r <= 32'h0;
         pll_ctrl_r <= `PLL_RST;
         pwr_r      <= 4'h0;
         filt_r     <= `FILT_RST;
         fmt_r      <= 2'h0;
         rate_r     <= 3'h0;
      end else if (por_r) begin
         clk_ctrl_r <= 32'h0;
         pll_ctrl_r <= `PLL_RST;
         pwr_r      <= 4'h0;
         filt_r     <= `FILT_RST;
         fmt_r      <= 2'h0;
         rate_r     <= 3'h0;
      end else if (wr_en) begin
         unique case (paddr)
            `OFF_CLK_CTRL:  clk_ctrl_r <= {28'h0, pwdata[3:0]};
            `OFF_PLL_CTRL:  pll_ctrl_r <= pwdata;
            `OFF_PWR_CTRL:  pwr_r <= pwdata[3:0];
            `OFF_FILT_CTRL: filt_r <= pwdata[1:0];
            `OFF_PORT_CTRL: fmt_r <= pwdata[1:0];
            `OFF_RATE_CTRL: rate_r <= pwdata[2:0];
            default: ;
         endcase
      end
   end
   // =========================================================
   // pll lock model
   // =========================================================
   logic pll_up;
   logic pll_go;
   // reference range is the analog side's; start is logic only
   assign pll_up = pwr_r[`PWR_PLL_BIT] && pll_ctrl_r[`PLL_START_BIT];
   assign pll_go = pll_up && pll_st_r == seq_pkg::PLL_OFF;
   assign lock_if.start = pll_go;
   seq_timer #(.COUNT(LOCK_CYCLES)) u_lock (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .abort    (!pll_up || por_r),
      .tif      (lock_if)
   );
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pll_st_r <= seq_pkg::PLL_OFF;
      end else begin
         // lock drops on pll down or reset
         if (!pll_up || por_r) begin
            pll_st_r <= seq_pkg::PLL_OFF;
         end else begin
            unique case (pll_st_r)
               seq_pkg::PLL_OFF:    pll_st_r <= seq_pkg::PLL_ACQ;
               seq_pkg::PLL_ACQ:    if (lock_if.done) begin
                  pll_st_r <= seq_pkg::PLL_LOCKED;
               end
               seq_pkg::PLL_LOCKED: pll_st_r <= seq_pkg::PLL_LOCKED;
               default:             pll_st_r <= seq_pkg::PLL_OFF;
            endcase
         end
      end
   end
   // =========================================================
   // interrupts
   // =========================================================
   assign irq_set[`IRQ_LOCK_BIT]   = lock_if.done && pll_up && !por_r;
   assign irq_set[`IRQ_UNLOCK_BIT] = pll_st_r == seq_pkg::PLL_LOCKED &&
                                     (!pll_up || por_r);
   assign irq_set[`IRQ_BAD_BIT]    = psel && penable && !pready && !acc_ok;
   logic irq_clr_hit;
   assign irq_clr_hit = wr_en && paddr == `OFF_IRQ_CLR;
   // one sticky bit per event; set wins over a same-cycle clear
   for (genvar i = 0; i < `IRQ_W; i++) begin : g_irq_stat
      always_ff @(posedge core_clk or negedge rst_n) begin
         if (!rst_n) begin
            irq_stat_r[i] <= 1'b0;
         end else if (irq_set[i]) begin
            irq_stat_r[i] <= 1'b1;
         end else if (irq_clr_hit && pwdata[i]) begin
            irq_stat_r[i] <= 1'b0;
         end
      end
   end
   // enables cleared with the other settings
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_en_r <= '0;
      end else if (por_r) begin
         irq_en_r <= '0;
      end else if (wr_en && paddr == `OFF_IRQ_EN) begin
         irq_en_r <= pwdata[`IRQ_W-1:0];
      end
   end
   // =========================================================
   // outputs
   // =========================================================
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         core_clk_gate <= 1'b0;
         pll_lock      <= 1'b0;
         por_active    <= 1'b1;
      end else begin
         // core clock gated by enable and, when the pll is the source, lock
         core_clk_gate <= ready_ok && !por_r;
         pll_lock      <= pll_st_r == seq_pkg::PLL_LOCKED;
         por_active    <= por_r;
      end
   end
   // settings show one cycle after the register write
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         blk_power     <= 4'h0;
         filt_128x     <= `FILT_RST;
         port_fmt      <= 2'h0;
         conv_rate     <= 3'h0;
      end else begin
         // dsp power passed through whether or not locked
         blk_power     <= pwr_r;
         filt_128x     <= filt_r;
         port_fmt      <= fmt_r;
         conv_rate     <= rate_r;
      end
   end
   // registered so the interrupt pin never glitches
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq           <= 1'b0;
      end else begin
         irq           <= |(irq_stat_r & irq_en_r);
      end
   end
endmodule : codec_startup_power_sequencer

// File: sim/codec_startup_power_sequencer_asserts.sv
// port-level checker for the startup and power sequencer
// assumes it is bound to the top module; one clock domain
`timescale 1ns/10ps
module codec_startup_power_sequencer_asserts #(
   parameter int POR_CYCLES  = 20,
   parameter int LOCK_CYCLES = 10
) (
   input wire logic        core_clk,          // core clock
   input wire logic        rst_n,             // async reset, low
   input wire logic        core_supply_point, // supply good
   input wire logic        psel,              // apb select
   input wire logic        penable,           // apb enable
   input wire logic        pwrite,            // apb direction
   input wire logic [11:0] paddr,             // apb address
   input wire logic [31:0] pwdata,            // apb write data
   input wire logic [31:0] prdata,            // apb read data
   input wire logic        pready,            // apb ready
   input wire logic        pslverr,           // apb error
   input wire logic        core_clk_gate,     // core clock on
   input wire logic        pll_lock,          // pll locked
   input wire logic        por_active,        // por held
   input wire logic [3:0]  blk_power,         // block power
   input wire logic [1:0]  filt_128x,         // filter ratio
   input wire logic [1:0]  port_fmt,          // framing
   input wire logic [2:0]  conv_rate,         // rate code
   input wire logic        irq                // interrupt
);
   int por_cnt;
   int lock_cnt;
   // ==========================================
   // cycle counters, restart when cause drops
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) por_cnt <= 0;
      else por_cnt <= por_active ? por_cnt + 1 : 0;
   end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) lock_cnt <= 0;
      else lock_cnt <= blk_power[2] ? lock_cnt + 1 : 0;
   end
   // ==========================================
   // properties
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence s_setup;  psel && !penable; endsequence
   sequence s_access; psel && penable;  endsequence
   sequence s_done;   psel && penable && pready; endsequence
   AST_ONE_WAIT: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
      else $error("pready not one wait state after access");
   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   AST_ERR_PAIRED: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   AST_IDLE_RDATA: assert property (!pready |-> prdata == 32'h0000_0000)
      else $error("read data outside answer cycle");
   AST_POR_DEFAULTS: assert property (por_active [*3] |->
      blk_power == 4'h0 && filt_128x == 2'h3 && !core_clk_gate && !pll_lock)
      else $error("defaults not held during power-on reset");
   AST_POR_LEN: assert property ($fell(por_active) |-> por_cnt >= POR_CYCLES)
      else $error("power-on reset too short");
   AST_POR_REFUSE: assert property ((s_done and por_active) |-> pslverr)
      else $error("access accepted during power-on reset");
   AST_LOCK_TIME: assert property ($rose(pll_lock) |-> lock_cnt >= LOCK_CYCLES)
      else $error("lock before acquisition time");
   AST_LOCK_DROP: assert property (!blk_power[2] [*2] |-> !pll_lock)
      else $error("lock shown with pll powered down");
   AST_PWR_WRITE: assert property ((s_done and
      pwrite && paddr == 12'h008 && !por_active) |->
      !pslverr ##1 blk_power == $past(pwdata[3:0]))
      else $error("power write refused or not applied");
endmodule : codec_startup_power_sequencer_asserts
bind codec_startup_power_sequencer codec_startup_power_sequencer_asserts #(
   .POR_CYCLES(POR_CYCLES), .LOCK_CYCLES(LOCK_CYCLES)) i_sva (
   .core_clk(core_clk), .rst_n(rst_n), .core_supply_point(core_supply_point),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .core_clk_gate(core_clk_gate), .pll_lock(pll_lock),
   .por_active(por_active), .blk_power(blk_power), .filt_128x(filt_128x),
   .port_fmt(port_fmt), .conv_rate(conv_rate), .irq(irq));

// File: sim/host_model.sv
// apb host controller model for the sequencer's control port
// assumes the bench calls its tasks; one clock
`timescale 1ns/10ps
module host_model (
   input  wire logic        core_clk, // core clock
   output logic             psel,     // apb select
   output logic             penable,  // apb enable
   output logic             pwrite,   // apb direction
   output logic      [11:0] paddr,    // apb address
   output logic      [31:0] pwdata,   // apb write data
   input  wire logic [31:0] prdata,   // apb read data
   input  wire logic        pready,   // apb ready
   input  wire logic        pslverr   // apb error
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
   end
   // ==========================================
   // one transfer; released data inverted so stale values never match
   task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
      @(posedge core_clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0; penable <= 1'b0; pwdata <= ~d;
   endtask : xfer
   // ==========================================
   // ordered bring-up
   task automatic bring_up(output logic e);
      logic [31:0] r;
      logic        e1;
      int          n;
      e = 1'b0;
      n = 0;
      xfer(1'b1, 12'h008, 32'h0, r, e1); e |= e1;    // pll down
      xfer(1'b1, 12'h004, 32'h1000, r, e1); e |= e1; // settings reset
      xfer(1'b1, 12'h008, 32'h4, r, e1); e |= e1;
      xfer(1'b1, 12'h004, 32'h1001, r, e1); e |= e1; // start
      do begin
         xfer(1'b0, 12'h014, 32'h0, r, e1); e |= e1;
         n++;
      end while (r[0] !== 1'b1 && n < 100);
      // dsp on at once after lock
      xfer(1'b1, 12'h000, 32'h9, r, e1); e |= e1;    // core clock on, pll src
      xfer(1'b1, 12'h008, 32'hc, r, e1); e |= e1;
   endtask : bring_up
endmodule : host_model

// File: sim/codec_startup_power_sequencer_tb.sv
// self-checking bench for the startup and power sequencer
// assumes host_model and the bound checker are compiled alongside
`timescale 1ns/10ps
module codec_startup_power_sequencer_tb;
   localparam int POR_CYC = 20;
   localparam int LOCK_CYC = 10;
   typedef struct {logic [11:0] a; logic [31:0] d;} row_t;
   logic core_clk, rst_n, core_supply_point, psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic pready, pslverr, core_clk_gate, pll_lock, por_active, irq, e, e2;
   logic [3:0] blk_power;
   logic [1:0] filt_128x, port_fmt;
   logic [2:0] conv_rate;
   int fail_count, num_checks, cyc, t0;
   row_t rows [14] = '{'{12'h00c, 32'h0}, '{12'h00c, 32'h1}, '{12'h00c, 32'h2},
      '{12'h00c, 32'h3}, '{12'h010, 32'h0}, '{12'h010, 32'h1}, '{12'h010, 32'h2},
      '{12'h010, 32'h3}, '{12'h024, 32'h0}, '{12'h024, 32'h6}, '{12'h008, 32'h5},
      '{12'h008, 32'h6}, '{12'h008, 32'h7}, '{12'h008, 32'hc}};
   codec_startup_power_sequencer #(.POR_CYCLES(POR_CYC), .LOCK_CYCLES(LOCK_CYC))
   i_dut (.core_clk(core_clk), .rst_n(rst_n),
      .core_supply_point(core_supply_point), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .core_clk_gate(core_clk_gate),
      .pll_lock(pll_lock), .por_active(por_active), .blk_power(blk_power),
      .filt_128x(filt_128x), .port_fmt(port_fmt), .conv_rate(conv_rate),
      .irq(irq));
   host_model i_host (.core_clk(core_clk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   initial core_clk = 1'b0;
   always #2.5 core_clk = ~core_clk;
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic settle;
      repeat (2) @(posedge core_clk);
      #1;
   endtask : settle
   function automatic logic [31:0] port_of(input logic [11:0] a);
      case (a)
         12'h008: port_of = {28'h0, blk_power};
         12'h00c: port_of = {30'h0, filt_128x};
         12'h010: port_of = {30'h0, port_fmt};
         default: port_of = {29'h0, conv_rate};
      endcase
   endfunction : port_of
   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : stop_test
   // ==========================================
   // run-length guard
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         stop_test();
      end
   end
   initial begin
      rst_n = 1'b0; core_supply_point = 1'b1;
      fail_count = 0; num_checks = 0;
      repeat (8) @(posedge core_clk);
      #1;
      chk(por_active, 1'b1); chk(filt_128x, 2'h3);
      chk(blk_power, 4'h0); chk(core_clk_gate, 1'b0);
      @(posedge core_clk);
      rst_n <= 1'b1;
      t0 = cyc;
      while (por_active !== 1'b0 && cyc - t0 < 500) @(posedge core_clk);
      chk(cyc - t0 >= POR_CYC, 1'b1);
      chk(por_active, 1'b0);
      $display("test por done");
      i_host.xfer(1'b0, 12'h00c, 32'h0, r, e);
      chk({e, r}, 33'h1_0000_0000);
      i_host.bring_up(e);
      settle();
      chk(e, 1'b0); chk(pll_lock, 1'b1);
      chk(blk_power, 4'hc); chk(core_clk_gate, 1'b1);
      $display("test bring-up done");
      foreach (rows[i]) begin
         i_host.xfer(1'b1, rows[i].a, rows[i].d, r, e);
         i_host.xfer(1'b0, rows[i].a, 32'h0, r, e2);
         settle();
         chk({e, e2, r}, {2'b00, rows[i].d});
         chk(port_of(rows[i].a), rows[i].d);
      end
      $display("test settings done");
      i_host.xfer(1'b1, 12'h01c, 32'h7, r, e);
      i_host.xfer(1'b1, 12'h020, 32'h4, r, e);
      i_host.xfer(1'b0, 12'h028, 32'h0, r, e);
      settle();
      chk({e, r, irq}, {1'b1, 32'h0, 1'b1});
      i_host.xfer(1'b0, 12'h018, 32'h0, r, e);
      chk(r, 32'h4);
      i_host.xfer(1'b1, 12'h01c, 32'h4, r, e);
      i_host.xfer(1'b0, 12'h01c, 32'h0, r, e);
      settle();
      chk({r, irq}, 33'h0);
      i_host.xfer(1'b1, 12'h020, 32'h0, r, e);
      i_host.xfer(1'b0, 12'h002, 32'h0, r, e);
      settle();
      chk({e, irq}, 2'b10);
      i_host.xfer(1'b0, 12'h018, 32'h0, r, e);
      chk(r, 32'h4);
      $display("test interrupt done");
      i_host.xfer(1'b1, 12'h00c, 32'h0, r, e);
      i_host.xfer(1'b1, 12'h008, 32'h0, r, e);
      settle();
      chk({pll_lock, core_clk_gate, filt_128x}, 4'h0);
      @(posedge core_clk);
      core_supply_point <= 1'b0;
      repeat (6) @(posedge core_clk);
      i_host.xfer(1'b0, 12'h000, 32'h0, r, e);
      #1;
      chk({e, por_active, filt_128x}, 4'hf);
      @(posedge core_clk);
      core_supply_point <= 1'b1;
      t0 = cyc;
      while (por_active !== 1'b0 && cyc - t0 < 500) @(posedge core_clk);
      chk(cyc - t0 >= POR_CYC, 1'b1);
      chk(por_active, 1'b0);
      $display("test supply drop done");
      stop_test();
   end
endmodule : codec_startup_power_sequencer_tb
